// ### rsp_sect.sv
package rsp_pkg;
  // Flash word address width and the fixed stalling-section size in words.
  localparam int ADDR_W = 17;
  localparam logic [16:0] FLASH_TOP = 17'h1ffff;
  localparam logic [16:0] STALL_WORDS = 17'h01000;
  // Boot-loader section sizes in words, chosen by the boot size fuse.
  localparam logic [16:0] BOOT_WORDS_0 = 17'h01000;
  localparam logic [16:0] BOOT_WORDS_1 = 17'h00800;
  localparam logic [16:0] BOOT_WORDS_2 = 17'h00400;
  localparam logic [16:0] BOOT_WORDS_3 = 17'h00200;
  // Wishbone register offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_ADDR = 8'h0c;
  // Control register fields.
  localparam int CTRL_BUSY_BIT = 0;
  localparam int CTRL_OP_BIT = 1;
  localparam int CTRL_HALT_BIT = 2;
  localparam int CTRL_CLR_BIT = 4;
  // Status and mask fields.
  localparam int EV_W = 3;
  localparam int EV_DONE = 0;
  localparam int EV_REFUSE = 1;
  localparam int EV_FETCH = 2;
  localparam logic [2:0] EV_RESET = 3'h0;
  localparam logic [2:0] MASK_RESET = 3'h0;
  // Store operation codes.
  localparam logic OP_ERASE = 1'b0;
  localparam logic OP_WRITE = 1'b1;
endpackage : rsp_pkg

module rsp_sect_decode (
  input wire logic [16:0] addr_i,
  input wire logic [1:0] boot_size_fuse_i,
  output logic boot_hit_o,
  output logic stall_hit_o
);
  function automatic logic [16:0] boot_start(input logic [1:0] sz);
    logic [16:0] words;
    case (sz)
      2'h0: words = rsp_pkg::BOOT_WORDS_0;
      2'h1: words = rsp_pkg::BOOT_WORDS_1;
      2'h2: words = rsp_pkg::BOOT_WORDS_2;
      default: words = rsp_pkg::BOOT_WORDS_3;
    endcase
    boot_start = rsp_pkg::FLASH_TOP - words + 17'h00001;
  endfunction : boot_start

  assign boot_hit_o = addr_i >= boot_start(boot_size_fuse_i);
  // boot inside stall section, since no boot size exceeds it.
  assign stall_hit_o =
    addr_i >= (rsp_pkg::FLASH_TOP - rsp_pkg::STALL_WORDS + 17'h00001);
endmodule : rsp_sect_decode

// ### rsp_ctrl.sv
// Operation
// - Store instructions fetched from the application section are refused.
// - Programming starts only for store instructions fetched from boot.
// - Boot-issued stores may target any flash address, boot included.
// - Programming concurrent-read section never halts the CPU.
// - Programming the stalling section halts the CPU until completion.
// - Halt depends on target address section, not executing section.
// - Boot-loader section always lies inside the stalling section.
// - Busy flag reads one while concurrent-read section is blocked.
// - Concurrent-read code is unreadable during any boot programming.
// - Boot size fuse sets the application/boot boundary.
// - Separate lock sets guard application and boot sections.
//
// Design decisions made here: the placing of the registers and the Wishbone slave port.
module rsp_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic program_store_instr_i,
  input wire logic program_store_op_i,
  input wire logic [16:0] program_store_pc_i,
  input wire logic [16:0] program_store_addr_i,
  input wire logic [1:0] boot_size_fuse_i,
  input wire logic [1:0] app_lock_i,
  input wire logic [1:0] boot_lock_i,
  input wire logic fetch_valid_i,
  input wire logic [16:0] fetch_addr_i,
  output logic flash_start_o,
  output logic flash_op_o,
  output logic [16:0] flash_addr_o,
  input wire logic flash_done_i,
  output logic cpu_halt_o,
  output logic rww_block_o,
  output logic irq_o
);
  typedef enum logic [0:0] {
    RSP_IDLE = 1'b0,
    RSP_BUSY = 1'b1
  } rsp_state_e;

  rsp_state_e state;
  logic rww_busy_flag;
  logic tgt_stall;
  logic [2:0] ev_stat;
  logic [2:0] ev_mask;
  logic [2:0] next_ev;
  logic pc_boot;
  logic tgt_boot;
  logic tgt_stall_hit;
  logic fetch_stall;
  logic lock_ok;
  logic accept;
  logic refuse;
  logic wb_req;
  logic wr_ctrl;
  logic clr_req;
  logic rd_stat;

  rsp_sect_decode u_pc_dec (
    .addr_i(program_store_pc_i),
    .boot_size_fuse_i(boot_size_fuse_i),
    .boot_hit_o(pc_boot),
    .stall_hit_o()
  );

  rsp_sect_decode u_tgt_dec (
    .addr_i(program_store_addr_i),
    .boot_size_fuse_i(boot_size_fuse_i),
    .boot_hit_o(tgt_boot),
    .stall_hit_o(tgt_stall_hit)
  );

  rsp_sect_decode u_fetch_dec (
    .addr_i(fetch_addr_i),
    .boot_size_fuse_i(boot_size_fuse_i),
    .boot_hit_o(),
    .stall_hit_o(fetch_stall)
  );

  // independent lock sets.
  // Lock bit 0 low means stores may not write that section.
  assign lock_ok = tgt_boot ? boot_lock_i[0] : app_lock_i[0];

  assign accept = program_store_instr_i && pc_boot && lock_ok &&
    (state == RSP_IDLE);
  assign refuse = program_store_instr_i && !accept;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_ctrl = wb_req && wb_we_i && (wb_adr_i == rsp_pkg::OFS_CTRL) &&
    wb_sel_i[0];
  assign clr_req = wr_ctrl && wb_dat_i[rsp_pkg::CTRL_CLR_BIT];
  assign rd_stat = wb_req && !wb_we_i && (wb_adr_i == rsp_pkg::OFS_STAT);

  // Sequencer: one operation at a time, the flash engine reports done.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= RSP_IDLE;
      tgt_stall <= 1'b0;
      cpu_halt_o <= 1'b0;
      flash_start_o <= 1'b0;
      flash_op_o <= rsp_pkg::OP_ERASE;
      flash_addr_o <= 17'h00000;
    end else begin
      flash_start_o <= 1'b0;
      case (state)
        RSP_IDLE: begin
          if (accept) begin
            state <= RSP_BUSY;
            flash_start_o <= 1'b1;
            flash_op_o <= program_store_op_i;
            flash_addr_o <= program_store_addr_i;
            tgt_stall <= tgt_stall_hit;
            cpu_halt_o <= tgt_stall_hit;
          end
        end
        RSP_BUSY: begin
          if (flash_done_i) begin
            state <= RSP_IDLE;
            cpu_halt_o <= 1'b0;
          end
        end
        default: begin
          state <= RSP_IDLE;
          cpu_halt_o <= 1'b0;
        end
      endcase
    end
  end

  // The flag also covers stall-section work, so concurrent-read code stays
  // unreadable for every boot operation, even after a halt ends.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rww_busy_flag <= 1'b0;
    end else if (accept) begin
      rww_busy_flag <= 1'b1;
    end else if (clr_req && state == RSP_IDLE) begin
      rww_busy_flag <= 1'b0;
    end
  end

  function automatic logic next_block(input logic acc, input logic flag,
                                      input logic clr, input rsp_state_e st);
    next_block = acc || (flag && !(clr && st == RSP_IDLE));
  endfunction : next_block

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rww_block_o <= 1'b0;
    end else begin
      rww_block_o <= next_block(accept, rww_busy_flag, clr_req, state);
    end
  end

  // Events: set wins over the read that clears.
  always_comb begin
    next_ev = ev_stat;
    if (rd_stat) begin
      next_ev = rsp_pkg::EV_RESET;
    end
    if (state == RSP_BUSY && flash_done_i) begin
      next_ev[rsp_pkg::EV_DONE] = 1'b1;
    end
    if (refuse) begin
      next_ev[rsp_pkg::EV_REFUSE] = 1'b1;
    end
    // a fetch from the blocked section is reported, not prevented.
    if (fetch_valid_i && rww_busy_flag && !fetch_stall) begin
      next_ev[rsp_pkg::EV_FETCH] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_stat <= rsp_pkg::EV_RESET;
    end else begin
      ev_stat <= next_ev;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_mask <= rsp_pkg::MASK_RESET;
    end else if (wb_req && wb_we_i && wb_adr_i == rsp_pkg::OFS_MASK &&
                 wb_sel_i[0]) begin
      ev_mask <= wb_dat_i[rsp_pkg::EV_W-1:0];
    end
  end

  // The interrupt follows the next status value, so it rises together with
  // the status bit that causes it rather than one cycle later.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(next_ev & ev_mask);
    end
  end

  // Wishbone slave: ack one cycle after the request, unmapped reads zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h00000000;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          rsp_pkg::OFS_CTRL: begin
            wb_dat_o[rsp_pkg::CTRL_BUSY_BIT] <= rww_busy_flag;
            wb_dat_o[rsp_pkg::CTRL_OP_BIT] <= (state == RSP_BUSY);
            wb_dat_o[rsp_pkg::CTRL_HALT_BIT] <= cpu_halt_o;
          end
          rsp_pkg::OFS_STAT: wb_dat_o[rsp_pkg::EV_W-1:0] <= ev_stat;
          rsp_pkg::OFS_MASK: wb_dat_o[rsp_pkg::EV_W-1:0] <= ev_mask;
          rsp_pkg::OFS_ADDR: wb_dat_o[16:0] <= flash_addr_o;
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_app_refuse;
    program_store_instr_i && !pc_boot |=> !flash_start_o;
  endproperty
  a_app_refuse: assert property (p_app_refuse)
    else $error("Application store started programming.");

  property p_boot_only;
    flash_start_o |-> $past(program_store_instr_i && pc_boot);
  endproperty
  a_boot_only: assert property (p_boot_only)
    else $error("Programming started without a boot fetch.");

  property p_boot_target;
    program_store_instr_i && pc_boot && tgt_boot && boot_lock_i[0] &&
      state == RSP_IDLE |=> flash_start_o;
  endproperty
  a_boot_target: assert property (p_boot_target)
    else $error("Boot store to boot section not started.");

  property p_no_halt;
    state == RSP_BUSY && !tgt_stall |-> !cpu_halt_o;
  endproperty
  a_no_halt: assert property (p_no_halt)
    else $error("CPU halted for concurrent-read programming.");

  property p_halt;
    state == RSP_BUSY && tgt_stall |-> cpu_halt_o;
  endproperty
  a_halt: assert property (p_halt)
    else $error("CPU not halted for stall-section programming.");

  property p_target_decides;
    flash_start_o |-> cpu_halt_o == $past(tgt_stall_hit);
  endproperty
  a_target_decides: assert property (p_target_decides)
    else $error("Halt not chosen by target section.");

  property p_boot_in_stall;
    tgt_boot |-> tgt_stall_hit;
  endproperty
  a_boot_in_stall: assert property (p_boot_in_stall)
    else $error("Boot section outside stalling section.");

  property p_block_flag;
    state == RSP_BUSY |-> rww_block_o && rww_busy_flag;
  endproperty
  a_block_flag: assert property (p_block_flag)
    else $error("Concurrent-read section readable while programming.");

  property p_flag_sticky;
    $fell(rww_busy_flag) |-> $past(clr_req && state == RSP_IDLE);
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("Busy flag dropped without software clear.");

  property p_lock;
    flash_start_o |-> $past(tgt_boot ? boot_lock_i[0] : app_lock_i[0]);
  endproperty
  a_lock: assert property (p_lock)
    else $error("Locked section was programmed.");

  property p_block_mirror;
    rww_block_o == rww_busy_flag;
  endproperty
  a_block_mirror: assert property (p_block_mirror)
    else $error("Block output differs from busy flag.");

  property p_flag_set;
    flash_start_o |-> rww_busy_flag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("Busy flag not set at operation start.");

  property p_halt_end;
    state == RSP_BUSY && flash_done_i |=> !cpu_halt_o && state == RSP_IDLE;
  endproperty
  a_halt_end: assert property (p_halt_end)
    else $error("Halt or operation outlived completion.");

  property p_fetch_event;
    fetch_valid_i && rww_busy_flag && !fetch_stall |=>
      ev_stat[rsp_pkg::EV_FETCH];
  endproperty
  a_fetch_event: assert property (p_fetch_event)
    else $error("Fetch from blocked section not reported.");

  property p_fuse_bound;
    tgt_boot == (program_store_addr_i >
      rsp_pkg::FLASH_TOP - (rsp_pkg::BOOT_WORDS_0 >> boot_size_fuse_i));
  endproperty
  a_fuse_bound: assert property (p_fuse_bound)
    else $error("Boot boundary does not follow the fuse.");

  c_rww_op: cover property (flash_start_o && !cpu_halt_o ##[1:20]
    state == RSP_IDLE);
  c_stall_op: cover property (flash_start_o && cpu_halt_o);
  c_refuse: cover property (refuse);
  c_clear: cover property (clr_req && rww_busy_flag && state == RSP_IDLE);
  c_fetch: cover property (fetch_valid_i && rww_busy_flag && !fetch_stall);
endmodule : rsp_ctrl

// ### rsp_flash_model.sv
module rsp_flash_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flash_start_i,
  input wire logic [7:0] delay_i,
  output logic flash_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt;
  // The engine answers after a delay chosen by the bench.
  // Every delay the bench sets lies between 16 and 47 cycles, so only slow completions are exercised.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 8'h00;
      flash_done_o <= 1'b0;
    end else begin
      flash_done_o <= cnt == 8'h01;
      if (flash_start_i) begin
        cnt <= delay_i;
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule : rsp_flash_model

// ### rsp_ctrl_tb.sv
module rsp_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, flash_start_o, flash_op_o, flash_done_i;
  logic cpu_halt_o, rww_block_o, irq_o;
  logic [16:0] flash_addr_o;
  logic program_store_instr_i = 1'b0, program_store_op_i = 1'b0;
  logic [16:0] program_store_pc_i = 17'h0, program_store_addr_i = 17'h0;
  logic fetch_valid_i = 1'b0;
  logic [16:0] fetch_addr_i = 17'h0;
  logic [1:0] boot_size_fuse_i = 2'h0;
  logic [1:0] app_lock_i = 2'h3, boot_lock_i = 2'h3;
  logic [7:0] dly = 8'h0a;
  logic [15:0] rnd = 16'h002d;
  int n_fail = 0, tests_run = 0, fs = 0, msk = 0;
  int exp_q[$];
  rsp_ctrl rsp_ctrl_i (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .program_store_instr_i(program_store_instr_i),
    .program_store_op_i(program_store_op_i),
    .program_store_pc_i(program_store_pc_i),
    .program_store_addr_i(program_store_addr_i),
    .boot_size_fuse_i(boot_size_fuse_i),
    .app_lock_i(app_lock_i),
    .boot_lock_i(boot_lock_i),
    .fetch_valid_i(fetch_valid_i),
    .fetch_addr_i(fetch_addr_i),
    .flash_start_o(flash_start_o),
    .flash_op_o(flash_op_o),
    .flash_addr_o(flash_addr_o),
    .flash_done_i(flash_done_i),
    .cpu_halt_o(cpu_halt_o),
    .rww_block_o(rww_block_o),
    .irq_o(irq_o)
  );
  rsp_flash_model rsp_flash_model_i (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flash_start_i(flash_start_o),
    .delay_i(dly),
    .flash_done_o(flash_done_i)
  );
  always #2 clk_i = ~clk_i;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic bit in_boot(input int a);
    return a >= 131072 - (4096 >> fs);
  endfunction : in_boot
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : chk
  task automatic chb(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask : chb
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  // The request is held until ack is seen high at a rising edge.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    chb("ack", 1'b1, wb_ack_o);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdc
  task automatic fetch(input logic [16:0] a);
    @(posedge clk_i);
    fetch_valid_i <= 1'b1;
    fetch_addr_i <= a;
    @(posedge clk_i);
    fetch_valid_i <= 1'b0;
  endtask : fetch
  // The model decides acceptance and halting from pc, target and locks.
  task automatic store(input int p, input int t, input logic o);
    bit ok;
    bit st;
    int n;
    @(posedge clk_i);
    ok = in_boot(p) && (in_boot(t) ? boot_lock_i[0] : app_lock_i[0]);
    st = t >= 131072 - 4096;
    if (ok) begin
      exp_q.push_back(t);
    end
    program_store_pc_i <= 17'(p);
    program_store_addr_i <= 17'(t);
    program_store_op_i <= o;
    program_store_instr_i <= 1'b1;
    @(posedge clk_i);
    program_store_instr_i <= 1'b0;
    #1;
    chb("start", ok, flash_start_o);
    chb("halt", ok && st, cpu_halt_o);
    chb("block", ok, rww_block_o);
    if (!ok) begin
      @(posedge clk_i) #1;
      @(posedge clk_i) #1;
      chb("irq", msk != 0, irq_o);
      rdc(rsp_pkg::OFS_STAT, 32'h2, "stat_refused");
      @(posedge clk_i) #1;
      chb("irq_clr", 1'b0, irq_o);
      return;
    end
    chb("op", o, flash_op_o);
    chk("addr", exp_q.pop_front(), {15'h0, flash_addr_o});
    wb(1'b1, rsp_pkg::OFS_CTRL, 32'h10);
    rdc(rsp_pkg::OFS_CTRL, st ? 32'h7 : 32'h3, "ctrl_busy");
    if (!st) begin
      fetch(17'h1f800);
      fetch(17'(t ^ 1));
    end
    #1;
    n = 0;
    while (flash_done_i !== 1'b1 && n < 300) begin
      @(posedge clk_i) #1;
      chb("halt_hold", st, cpu_halt_o);
      n++;
    end
    chb("done_seen", 1'b1, flash_done_i);
    @(posedge clk_i) #1;
    chb("halt_end", 1'b0, cpu_halt_o);
    chb("block_hold", 1'b1, rww_block_o);
    @(posedge clk_i) #1;
    chb("irq", msk != 0, irq_o);
    rdc(rsp_pkg::OFS_STAT, st ? 32'h1 : 32'h5, "stat_done");
    rdc(rsp_pkg::OFS_ADDR, 32'(t), "addr_reg");
    rdc(rsp_pkg::OFS_CTRL, 32'h1, "busy_flag");
    wb(1'b1, rsp_pkg::OFS_CTRL, 32'h10);
    rdc(rsp_pkg::OFS_CTRL, 32'h0, "busy_clr");
    chb("block_clr", 1'b0, rww_block_o);
    chb("irq_clr", 1'b0, irq_o);
  endtask : store
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chb("halt_rst", 1'b0, cpu_halt_o);
    chb("irq_rst", 1'b0, irq_o);
    rdc(rsp_pkg::OFS_MASK, 32'(rsp_pkg::MASK_RESET), "mask_rst");
    rdc(rsp_pkg::OFS_STAT, 32'(rsp_pkg::EV_RESET), "stat_rst");
    wb(1'b1, rsp_pkg::OFS_ADDR, 32'h1234);
    rdc(rsp_pkg::OFS_ADDR, 32'h0, "addr_ro");
    rdc(8'h10, 32'h0, "unmapped");
    wb(1'b1, rsp_pkg::OFS_MASK, 32'h7);
    msk = 7;
    rdc(rsp_pkg::OFS_MASK, 32'h7, "mask_rw");
    for (int f = 0; f < 4; f++) begin
      fs = f;
      boot_size_fuse_i <= 2'(f);
      rnd = lfsr(rnd);
      dly <= 8'd16 + 8'(rnd[4:0]);
      store(131072 - (4096 >> f), int'(rnd[14:0]), rnd[15]);
      store(131071, 131072 - (4096 >> f), 1'b0);
      store(131071 - (4096 >> f), 256, 1'b1);
      store(131072 - (4096 >> f), 126976, 1'b1);
    end
    app_lock_i <= 2'h2;
    store(131071, 64, 1'b0);
    app_lock_i <= 2'h3;
    boot_lock_i <= 2'h2;
    store(131071, 131008, 1'b1);
    store(131071, 64, 1'b0);
    wb(1'b1, rsp_pkg::OFS_MASK, 32'h0);
    msk = 0;
    store(0, 64, 1'b0);
    end_sim;
  end
  // The run needs under a thousand cycles, so this limit of 25000 cycles is generous.
  initial begin
    #100000;
    n_fail++;
    end_sim;
  end
endmodule : rsp_ctrl_tb
